//--- design/ncom_params.svh
// Constants for the NCO modulation control block
`ifndef NCOM_PARAMS_SVH
`define NCOM_PARAMS_SVH
// Register indices; byte address is four times the index
`define NCOM_IDX_CENTER0 5'h00
`define NCOM_IDX_OFFSET0 5'h06
`define NCOM_IDX_CTRL    5'h0d
`define NCOM_IDX_UPDATE  5'h0f
`define NCOM_IDX_STATUS  5'h10
`define NCOM_FREQ_BYTES  6
// Control register fields and reset values
`define NCOM_CTRL_ACC_RUN 5
`define NCOM_CTRL_RST     8'h20
`define NCOM_CENTER_RST   48'h4000_0000_0000
`define NCOM_OFFSET_RST   48'h0000_0000_0000
// Pin to output latency of the offset enable, in master clocks
`define NCOM_OFFSET_FREQ_ENABLE_PIN_LAT    14
// Register stages of that path besides the matching delay line
`define NCOM_OFFSET_FREQ_ENABLE_PIN_FIXED  6
`endif

//--- design/ncom_pkg.sv
// Types shared by the NCO modulation control block
package ncom_pkg;
  // Modulation pins after synchronisation
  typedef struct packed {
    logic       update;
    logic [1:0] phase_sel;
    logic       offset_en;
  } ncom_pins_type;
  // Classic Wishbone request as seen by the slave
  typedef struct packed {
    logic        cyc;
    logic        stb;
    logic        we;
    logic [3:0]  sel;
    logic [4:0]  idx;
    logic [31:0] dat;
  } ncom_wb_req_type;
endpackage

//--- design/ncom_core.sv
// NCO with FSK and PSK modulation control behind a Wishbone slave
// What this block does
// - Output one 14-bit converter sample every master clock cycle.
// - Offset enable change reaches the output exactly fourteen clocks later.
// - Offset enable accepted every two clocks; controller toggles no faster.
// - Each 8-bit register takes one write strobe.
// - Phase selects accepted every two clocks; controller toggles no faster.
// - Clearing then setting control bit 5 zeroes the phase accumulator.
// - Phase selects give offsets of 0, 90, 180 and 270 degrees.
// - Offset enable adds offset word to center word, else adds zero.
// - Phase select, offset enable and update pins pass two-flop synchronisers.
`include "ncom_params.svh"
`timescale 1ns/100ps
`default_nettype none
module ncom_core #(
  parameter int ACC_W = 48,
  parameter int DAC_W = 14
) (
  input  wire logic             clk_i,
  input  wire logic             rst_i,
  input  wire logic             wb_cyc_i,
  input  wire logic             wb_stb_i,
  input  wire logic             wb_we_i,
  input  wire logic [3:0]       wb_sel_i,
  input  wire logic [31:0]      wb_adr_i,
  input  wire logic [31:0]      wb_dat_i,
  output logic      [31:0]      wb_dat_o,
  output logic                  wb_ack_o,
  input  wire logic             offset_freq_enable_pin_i,
  input  wire logic             phase_select_lsb_i,
  input  wire logic             phase_select_msb_i,
  input  wire logic             update_pin_i,
  output logic      [DAC_W-1:0] dac_sample_o
);
  // Delay line length that pads the pin path to its fixed latency
  localparam int DLY = `NCOM_OFFSET_FREQ_ENABLE_PIN_LAT - `NCOM_OFFSET_FREQ_ENABLE_PIN_FIXED;
  localparam int NB  = `NCOM_FREQ_BYTES;

  // ********************************************************
  // Pin synchronisers
  // ********************************************************
  ncom_pkg::ncom_pins_type pin_raw;
  ncom_pkg::ncom_pins_type s1_q;
  ncom_pkg::ncom_pins_type s2_q;
  ncom_pkg::ncom_pins_type s1_d;
  ncom_pkg::ncom_pins_type s2_d;
  logic                    upd_prev_q;
  logic                    upd_prev_d;

  // Pins gathered in one word so both stages move together
  assign pin_raw = {update_pin_i, phase_select_msb_i, phase_select_lsb_i,
                    offset_freq_enable_pin_i};

  // Two stages; only the second stage feeds any logic
  always_comb begin
    s1_d       = pin_raw;
    s2_d       = s1_q;
    upd_prev_d = s2_q.update;
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      s1_q       <= '0;
      s2_q       <= '0;
      upd_prev_q <= 1'b0;
    end else begin
      s1_q       <= s1_d;
      s2_q       <= s2_d;
      upd_prev_q <= upd_prev_d;
    end
  end

  // ********************************************************
  // Wishbone slave and register file
  // ********************************************************
  ncom_pkg::ncom_wb_req_type req;
  logic [7:0]  mctr_q [NB];   // Master copy of center word bytes
  logic [7:0]  mctr_d [NB];
  logic [7:0]  moff_q [NB];   // Master copy of offset word bytes
  logic [7:0]  moff_d [NB];
  logic [7:0]  ctrl_q;
  logic [7:0]  ctrl_d;
  logic        ack_d;
  logic [31:0] rdat_d;
  logic        wr_upd;
  logic        xfer;

  assign req = '{cyc: wb_cyc_i, stb: wb_stb_i, we: wb_we_i, sel: wb_sel_i,
                 idx: wb_adr_i[6:2], dat: wb_dat_i};

  // Answer one cycle after the request; ack drops the cycle after
  always_comb begin
    ack_d  = req.cyc && req.stb && !wb_ack_o;
    mctr_d = mctr_q;
    moff_d = moff_q;
    ctrl_d = ctrl_q;
    rdat_d = 32'h0000_0000;
    wr_upd = 1'b0;
    for (int i = 0; i < NB; i++) begin
      if (req.idx == `NCOM_IDX_CENTER0 + 5'(i)) begin
        rdat_d = {24'h00_0000, mctr_q[i]};
      end
      if (req.idx == `NCOM_IDX_OFFSET0 + 5'(i)) begin
        rdat_d = {24'h00_0000, moff_q[i]};
      end
    end
    if (req.idx == `NCOM_IDX_CTRL) begin
      rdat_d = {24'h00_0000, ctrl_q};
    end
    if (req.idx == `NCOM_IDX_STATUS) begin
      // Live view of the synchronised modulation pins
      rdat_d = {28'h000_0000, s2_q.update, s2_q.phase_sel, s2_q.offset_en};
    end
    // One byte per strobe, landing on the edge where ack is seen
    if (wb_ack_o && req.cyc && req.stb &&
        req.we && req.sel[0]) begin
      for (int i = 0; i < NB; i++) begin
        if (req.idx == `NCOM_IDX_CENTER0 + 5'(i)) begin
          mctr_d[i] = req.dat[7:0];
        end
        if (req.idx == `NCOM_IDX_OFFSET0 + 5'(i)) begin
          moff_d[i] = req.dat[7:0];
        end
      end
      if (req.idx == `NCOM_IDX_CTRL) begin
        ctrl_d = req.dat[7:0];
      end
      // Any write here acts like the update pin, saving a pin
      wr_upd = (req.idx == `NCOM_IDX_UPDATE);
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
      ctrl_q   <= `NCOM_CTRL_RST;
      for (int i = 0; i < NB; i++) begin
        mctr_q[i] <= 8'(`NCOM_CENTER_RST >> (8 * i));
        moff_q[i] <= 8'(`NCOM_OFFSET_RST >> (8 * i));
      end
    end else begin
      wb_ack_o <= ack_d;
      wb_dat_o <= ack_d ? rdat_d : 32'h0000_0000;
      ctrl_q   <= ctrl_d;
      mctr_q   <= mctr_d;
      moff_q   <= moff_d;
    end
  end

  // ********************************************************
  // Active frequency words, loaded on update
  // ********************************************************
  logic [ACC_W-1:0] center_q;
  logic [ACC_W-1:0] center_d;
  logic [ACC_W-1:0] offset_q;
  logic [ACC_W-1:0] offset_d;

  // Rising edge of the update pin or a write to the update index
  assign xfer = wr_upd || (s2_q.update && !upd_prev_q);

  // All bytes move together, so a multi-byte change lands at once
  always_comb begin
    center_d = center_q;
    offset_d = offset_q;
    if (xfer) begin
      for (int i = 0; i < NB; i++) begin
        center_d[8*i +: 8] = mctr_q[i];
        offset_d[8*i +: 8] = moff_q[i];
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      center_q <= ACC_W'(`NCOM_CENTER_RST);
      offset_q <= ACC_W'(`NCOM_OFFSET_RST);
    end else begin
      center_q <= center_d;
      offset_q <= offset_d;
    end
  end

  // ********************************************************
  // Modulation pipeline and accumulator
  // ********************************************************
  logic [DLY-1:0]   en_dly_q;
  logic [DLY-1:0]   en_dly_d;
  logic [ACC_W-1:0] freq_q;
  logic [ACC_W-1:0] freq_d;
  logic [ACC_W-1:0] acc_q;
  logic [ACC_W-1:0] acc_d;
  logic [ACC_W-1:0] phase_q;
  logic [ACC_W-1:0] phase_d;
  logic [DAC_W-1:0] dac_d;

  // Delay line pads the enable path to its fixed latency; each stage
  // takes a new level every clock, so toggling at half rate is safe
  always_comb begin
    en_dly_d = {en_dly_q[DLY-2:0], s2_q.offset_en};
    // Offset word joins only while enabled, else contributes zero
    freq_d   = center_q + (en_dly_q[DLY-1] ? offset_q
                                           : {ACC_W{1'b0}});
    // Clearing the run bit zeroes the accumulator feedback
    acc_d    = ctrl_q[`NCOM_CTRL_ACC_RUN] ? acc_q + freq_q
                                          : {ACC_W{1'b0}};
    // Quarter-turn offsets land in the two top phase bits
    phase_d  = acc_q + {s2_q.phase_sel, {(ACC_W-2){1'b0}}};
    // Sample is the top phase bits; a shape table would follow here
    dac_d    = phase_q[ACC_W-1 -: DAC_W];
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      en_dly_q     <= '0;
      freq_q       <= '0;
      acc_q        <= '0;
      phase_q      <= '0;
      dac_sample_o <= '0;
    end else begin
      en_dly_q     <= en_dly_d;
      freq_q       <= freq_d;
      acc_q        <= acc_d;
      phase_q      <= phase_d;
      dac_sample_o <= dac_d;
    end
  end

  // ********************************************************
  // Checks
  // ********************************************************
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  // Bus answer: one pulse, one cycle after the request
  ack_one_pulse_a : assert property (
    wb_ack_o |=> !wb_ack_o)
    else $error("ack held longer than one cycle");
  ack_next_cycle_a : assert property (
    wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("request not answered in one cycle");
  // Read data shows only in the ack cycle
  rd_data_idle_a : assert property (
    !wb_ack_o |-> wb_dat_o == 32'h0000_0000)
    else $error("read data outside the ack cycle");
  // Writes land at the edge where the master sees ack
  ctrl_write_a : assert property (
    wb_cyc_i && wb_stb_i && wb_we_i && wb_sel_i[0] && wb_ack_o &&
    wb_adr_i[6:2] == `NCOM_IDX_CTRL |=> ctrl_q == $past(wb_dat_i[7:0]))
    else $error("control write not stored");
  // Every pin passes exactly two flops before use
  pin_sync_a : assert property (
    ##2 s2_q.offset_en == $past(offset_freq_enable_pin_i, 2))
    else $error("offset enable not synchronised in two stages");
  phase_sync_a : assert property (
    ##2 s2_q.phase_sel ==
      $past({phase_select_msb_i, phase_select_lsb_i}, 2))
    else $error("phase selects not synchronised in two stages");
  update_sync_a : assert property (
    ##2 s2_q.update == $past(update_pin_i, 2))
    else $error("update pin not synchronised in two stages");
  // Delay line takes a fresh level every clock
  line_step_a : assert property (
    ##1 en_dly_q[0] == $past(s2_q.offset_en))
    else $error("delay line dropped a level");
  enable_delay_a : assert property (
    ##12 en_dly_q[DLY-1] == $past(offset_freq_enable_pin_i, 10))
    else $error("offset enable latency wrong");
  // Offset word joins only while enabled
  offset_gate_a : assert property (
    !en_dly_q[DLY-1] |=> freq_q == $past(center_q))
    else $error("offset word leaked while disabled");
  offset_add_a : assert property (
    en_dly_q[DLY-1] |=>
      freq_q == ACC_W'($past(center_q) + $past(offset_q)))
    else $error("offset word not added while enabled");
  // Active words move only on update; the load check compares the top byte of each word
  word_hold_a : assert property (
    !xfer |=> $stable(center_q) && $stable(offset_q))
    else $error("active word changed without update");
  word_load_a : assert property (
    xfer |=> center_q[ACC_W-1 -: 8] == $past(mctr_q[NB-1]) &&
      offset_q[ACC_W-1 -: 8] == $past(moff_q[NB-1]))
    else $error("active word not loaded on update");
  // Accumulator: zeroed while stopped, else one word per clock
  acc_zero_a : assert property (
    !ctrl_q[`NCOM_CTRL_ACC_RUN] |=> acc_q == '0 ##1 phase_q[ACC_W-3:0] == '0)
    else $error("accumulator not zeroed");
  acc_step_a : assert property (
    ctrl_q[`NCOM_CTRL_ACC_RUN] |=>
      acc_q == ACC_W'($past(acc_q) + $past(freq_q)))
    else $error("accumulator step wrong");
  // Quadrant offset and one sample per clock
  phase_quad_a : assert property (
    ##1 phase_q[ACC_W-1 -: 2] ==
      2'($past(acc_q[ACC_W-1 -: 2]) + $past(s2_q.phase_sel)))
    else $error("phase offset quadrant wrong");
  sample_out_a : assert property (
    ##1 dac_sample_o == $past(phase_q[ACC_W-1 -: DAC_W]))
    else $error("sample not taken from phase");
endmodule
`default_nettype wire

//--- verification/ncom_pin_drv.sv
// Controller model that drives the offset enable and phase select pins of the block
`timescale 1ns/100ps
`default_nettype none
module ncom_pin_drv (
  input  wire logic       clk_i,
  input  wire logic       rst_i,
  input  wire logic       ofs_want_i,
  input  wire logic [1:0] ph_want_i,
  output logic            ofs_pin_o,
  output logic      [1:0] ph_pin_o
);
  logic hold_q;
  // Pins rest one clock after each move, so the bench may ask every clock
  always @(posedge clk_i) begin
    if (rst_i) begin
      {ofs_pin_o, ph_pin_o, hold_q} <= 4'h0;
    end else if (hold_q) begin
      hold_q <= 1'b0;
    end else if ({ofs_want_i, ph_want_i} != {ofs_pin_o, ph_pin_o}) begin
      ofs_pin_o <= ofs_want_i;
      ph_pin_o  <= ph_want_i;
      hold_q    <= 1'b1;
    end
  end
endmodule
`default_nettype wire

//--- verification/tb_top.sv
// Self-checking bench for the NCO modulation control block
`include "ncom_params.svh"
`timescale 1ns/100ps
`default_nettype none
module tb_top;
  logic        clk_i, rst_i, cyc, stb, we, ack, ofs_want, ofs_pin, upd;
  logic [1:0]  ph_want, ph_pin, q0;
  logic [3:0]  sel;
  logic [31:0] adr, wdat, rdat, rv;
  logic [13:0] dac, prev, d, ofs, stp, s0;
  logic [15:0] hist;
  logic [7:0]  b;
  int          n_fail, checks, seed, k;
  ncom_core u_ncom_core (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc),
    .wb_stb_i(stb), .wb_we_i(we), .wb_sel_i(sel), .wb_adr_i(adr),
    .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
    .offset_freq_enable_pin_i(ofs_pin), .phase_select_lsb_i(ph_pin[0]),
    .phase_select_msb_i(ph_pin[1]), .update_pin_i(upd),
    .dac_sample_o(dac));
  ncom_pin_drv u_ncom_pin_drv (.clk_i(clk_i), .rst_i(rst_i),
    .ofs_want_i(ofs_want), .ph_want_i(ph_want), .ofs_pin_o(ofs_pin),
    .ph_pin_o(ph_pin));
  initial begin
    clk_i = 1'b0;
    forever #5 clk_i = ~clk_i;
  end
  // Offset pin history, bit 0 holds the level of the last cycle
  always @(posedge clk_i) hist <= {hist[14:0], ofs_pin};
  task automatic chk(input string nm, input logic [31:0] e, g);
    checks++;
    if (g !== e) begin
      n_fail++;
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic give_verdict();
    $display("checks %0d n_fail %0d", checks, n_fail);
    if (n_fail == 0 && checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  // Classic cycle; the idle edge before each keeps writes below half rate
  task automatic wb(input logic w, input logic [4:0] i, input logic [7:0] v);
    int n;
    @(posedge clk_i);
    {cyc, stb, we, sel} <= {2'b11, w, 4'h1};
    {adr, wdat} <= {25'h0, i, 2'b00, 24'h0, v};
    n = 0;
    do begin
      @(posedge clk_i);
      n++;
    end while (ack !== 1'b1 && n < 50);
    rv = rdat;
    {cyc, stb} <= 2'b00;
    if (ack !== 1'b1) begin
      n_fail++;
      give_verdict();
    end
  endtask
  // One clock later, returns the step the sample made; values read at
  // the edge are those settled just before it, as is the history
  task automatic tick(output logic [13:0] dl);
    @(posedge clk_i);
    dl = dac - prev;
    prev = dac;
  endtask
  // ****************************************
  // Main sequence
  // ****************************************
  initial begin
    seed = 23;
    {cyc, stb, we, sel, adr, wdat, ofs_want, ph_want, upd} = '0;
    {n_fail, checks, prev, stp} = '0;
    rst_i = 1'b1;
    repeat (6) @(posedge clk_i);
    rst_i <= 1'b0;
    #1;
    chk("dac after reset", 0, dac);
    wb(0, `NCOM_IDX_CTRL, 0);
    chk("ctrl reset", `NCOM_CTRL_RST, rv);
    wb(0, 5'h05, 0);
    chk("center msb reset", 8'h40, rv);
    wb(1, 5'h1f, 8'h5a);
    wb(0, 5'h1f, 0);
    chk("unmapped read", 0, rv);
    tick(d);
    stp = 14'h1000;
    repeat (4) tick(d);
    chk("steady step", stp, d);
    $display("test reset done");
    b = 8'($random(seed));
    ofs = {b, 6'h0};
    wb(1, 5'(`NCOM_IDX_OFFSET0 + 5), b);
    wb(1, `NCOM_IDX_UPDATE, 0);
    tick(d);
    for (k = 0; k < 60; k++) begin
      ofs_want <= (k < 20) ? 1'b1 : 1'($random(seed));
      tick(d);
      chk("bfsk step", 14'(stp + (hist[13] ? ofs : 14'h0)),
          d);
    end
    ofs_want <= 1'b0;
    repeat (20) tick(d);
    $display("test bfsk done");
    for (k = 0; k < 8; k++) begin
      q0 = ph_pin;
      s0 = dac;
      repeat (3) begin
        ph_want <= 2'($random(seed));
        tick(d);
      end
      repeat (9) tick(d);
      chk("psk phase", 14'(s0 + stp * 12 + {ph_pin - q0, 12'h0}), dac);
    end
    ofs_want <= 1'b1;
    repeat (6) tick(d);
    wb(0, `NCOM_IDX_STATUS, 0);
    chk("status pins", {ph_pin, ofs_pin}, rv[2:0]);
    ofs_want <= 1'b0;
    repeat (20) tick(d);
    $display("test psk done");
    for (k = 0; k < 3; k++) begin
      b = 8'($random(seed));
      wb(1, 5'h05, b);
      tick(d);
      tick(d);
      chk("step before update", stp, d);
      if (k == 1) begin
        upd <= 1'b1;
        repeat (4) tick(d);
        upd <= 1'b0;
      end else wb(1, `NCOM_IDX_UPDATE, 0);
      stp = {b, 6'h0};
      repeat (8) tick(d);
      tick(d);
      chk("mary step", stp, d);
    end
    $display("test mary done");
    q0 = ph_pin;
    wb(1, `NCOM_IDX_CTRL, 8'h00);
    // Write lands as ack is seen; the zeroed phase shows four edges on
    repeat (4) tick(d);
    chk("stopped phase", {q0, 12'h0}, dac);
    tick(d);
    chk("stopped step", 0, d);
    wb(1, `NCOM_IDX_CTRL, `NCOM_CTRL_RST);
    repeat (8) tick(d);
    tick(d);
    chk("restart step", stp, d);
    $display("test restart done");
    give_verdict();
  end
  // Cuts a hang short
  initial begin
    repeat (20000) @(posedge clk_i);
    n_fail++;
    give_verdict();
  end
endmodule
`default_nettype wire
